// >>> include/front_panel_regs.vh
// register map, fields, reset values and timing of the front panel
`ifndef FRONT_PANEL_REGS_VH
`define FRONT_PANEL_REGS_VH

// byte offsets, one aligned word each
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04
`define REG_CHAN 8'h08
`define REG_LINK 8'h0c

// config fields
`define CFG_RANGE_LSB 0
`define CFG_RANGE_MSB 6
`define CFG_RANGE_RST 7'h01

// status fields
`define ST_LOCKED 0
`define ST_MANAGED 1
`define ST_MANUAL 2
`define ST_PENDING 3
`define ST_SLOT_LSB 8
`define ST_SLOT_MSB 11
`define ST_TYPE_LSB 12
`define ST_TYPE_MSB 14

// control data slot range and types
`define SLOT_FIRST 4'h1
`define SLOT_LAST 4'he
`define TYPE_NONE 3'h0
`define TYPE_SERIAL 3'h1
`define TYPE_MUSIC_IN 3'h2
`define TYPE_MUSIC_OUT 3'h3
`define TYPE_GP_IN 3'h4
`define TYPE_GP_OUT 3'h5
`define TYPE_LAST 3'h5

// flash timing
`define CLK_KHZ 50000
`define BLINK_MS 250
`define BLINK_CYCLES (`BLINK_MS * `CLK_KHZ)

`endif

// >>> hw/button_sync.v
// two-flop synchroniser with rising-edge pulse for front-panel buttons
`timescale 1ns/1ps
`default_nettype none

module button_sync #(
    parameter WIDTH = 8
) (
    input wire ref_clk, // system clock
    input wire rst, // async reset, active high
    input wire [WIDTH-1:0] raw, // button levels from pins
    output wire [WIDTH-1:0] press // one-cycle pulse per new press
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;
    reg [WIDTH-1:0] last;

    // meta feeds only stable, never logic
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta <= {WIDTH{1'b0}};
            stable <= {WIDTH{1'b0}};
            last <= {WIDTH{1'b0}};
        end else begin
            meta <= raw;
            stable <= meta;
            last <= stable;
        end
    end

    assign press = stable & ~last;
endmodule // button_sync

`default_nettype wire

// >>> hw/front_panel_lock_and_cable_slots.v
// front-panel lock, managed mode, slot query and control data slot logic
// Notes on behaviour
// RULE1 - stereo link only for an odd channel and the next even one
// RULE2 - a pair linked at an input module lights matching indicators
// RULE3 - sides of a linked pair keep separate activation states
// RULE4 - managed mode requests taken only at the control master
// RULE5 - managed press flashes both indicators; confirm applies, cancel restores
// RULE6 - leaving managed mode restores the prior auto or manual mode
// RULE7 - in managed mode channel and slot buttons only display; other edits rejected
// RULE8 - edit lock belongs to this module only
// RULE9 - lock press blinks confirm indicator; confirm locks, cancel stays unlocked
// RULE10 - when locked, lock press then confirm unlocks; cancel stays locked
// RULE11 - locked panel ignores all but unlock sequence, channel queries, slot stepping
// RULE12 - locked channel press shows range start plus channel number minus one
// RULE13 - a slot query leaves channel activation unchanged
// RULE14 - managed mode gives query information whatever the lock state
// RULE15 - fourteen slots always offered, none reserved for a type
// RULE16 - selected slot steps 1 to 14 and wraps at both ends
// RULE17 - in-use lit only for an input assignment on the network
// RULE18 - types are serial, music in, music out, general in, general out, none
// RULE19 - an input-assigned slot carries only its type until its owner releases it
// RULE20 - type selector steps types, flashes confirm; confirm commits, cancel discards
// RULE21 - selecting none and confirming releases the input assignment
// RULE22 - output assignments reserve no slot; only inputs do
// RULE23 - auto/manual mode switchable only at the control master
// RULE24 - one pending confirm operation at a time; indicator stops when resolved
`timescale 1ns/1ps
`default_nettype none
`include "front_panel_regs.vh"

module front_panel_lock_and_cable_slots #(
    parameter CHANNELS = 16,
    parameter SLOTS = 14,
    parameter BLINK_CYCLES = `BLINK_CYCLES
) (
    input wire ref_clk, // 50 MHz system clock
    input wire rst, // async reset, active high
    // ahb-lite slave
    input wire hsel, // slave select
    input wire [7:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write when high
    input wire [2:0] hsize, // transfer size, word only
    input wire [31:0] hwdata, // write data
    input wire hready, // bus ready
    output wire hreadyout, // slave ready, never stalls
    output wire hresp, // always okay
    output reg [31:0] hrdata, // read data
    // front-panel buttons (pins)
    input wire btn_managed, // managed button
    input wire btn_lock, // edit lock button
    input wire btn_confirm, // enter
    input wire btn_cancel, // cancel
    input wire btn_mode, // auto/manual selector
    input wire btn_slot_inc, // data slot increment
    input wire btn_slot_dec, // data slot decrement
    input wire btn_type_sel, // data type selector
    input wire [CHANNELS-1:0] btn_chan, // channel buttons
    // network state (same clock)
    input wire is_control_master, // this module is control master
    input wire link_evt, // pulse: link change from an input module
    input wire [3:0] link_first, // first channel index (0-based)
    input wire [3:0] link_second, // second channel index (0-based)
    input wire link_on, // link or unlink
    input wire [SLOTS-1:0] net_slot_busy, // slot input-claimed by a peer
    input wire [3*SLOTS-1:0] net_slot_type, // peer type per slot
    // indicators and network outputs
    output reg [CHANNELS-1:0] chan_active, // channel active leds
    output wire [CHANNELS-1:0] stereo_pair_indicator, // link leds
    output reg [6:0] net_slot_display, // network slot display
    output wire [3:0] data_slot_display, // selected control data slot
    output wire slot_in_use, // in-use led
    output reg [5:0] type_indicator, // one-hot type leds, bit0 none
    output wire confirm_pending_indicator, // flashes while an op waits
    output wire managed_indicator, // managed led
    output wire lock_indicator, // edit lock led
    output reg managed_mode, // network under computer control
    output reg net_mode_manual, // local network mode, manual when high
    output reg assign_evt, // pulse: local assignment changed
    output reg [3:0] assign_slot, // slot of that change
    output reg [2:0] assign_type // new type, none releases
);
    localparam PAIRS = CHANNELS / 2;
    // pending operation states, one-hot
    localparam ST_IDLE = 5'b00001;
    localparam ST_MANAGED = 5'b00010;
    localparam ST_LOCK = 5'b00100;
    localparam ST_TYPE = 5'b01000;
    localparam ST_MODE = 5'b10000;

    wire [CHANNELS+7:0] press;
    wire p_managed = press[0];
    wire p_lock = press[1];
    wire p_confirm = press[2];
    wire p_cancel = press[3];
    wire p_mode = press[4];
    wire p_inc = press[5];
    wire p_dec = press[6];
    wire p_type = press[7];
    wire [CHANNELS-1:0] p_chan = press[CHANNELS+7:8];

    button_sync #(
        .WIDTH(CHANNELS + 8)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .raw({btn_chan, btn_type_sel, btn_slot_dec, btn_slot_inc, btn_mode,
              btn_cancel, btn_confirm, btn_lock, btn_managed}),
        .press(press)
    );

    reg [4:0] state;
    reg locked;
    reg saved_manual;
    reg [3:0] sel_slot;
    reg [2:0] cand_type;
    reg [2:0] slot_type [0:SLOTS-1];
    reg [PAIRS-1:0] link_pairs;
    reg [6:0] range_start;
    reg [31:0] blink_cnt;
    reg blink;

    // input kinds reserve a slot; outputs never do
    function is_input;
        input [2:0] t;
        begin
            is_input = (t == `TYPE_SERIAL) || (t == `TYPE_MUSIC_IN) || (t == `TYPE_GP_IN); // [RULE22]
        end
    endfunction

    // output type allowed on a slot fed by that input type
    function [2:0] out_for;
        input [2:0] t;
        begin
            case (t)
                `TYPE_SERIAL: out_for = `TYPE_SERIAL;
                `TYPE_MUSIC_IN: out_for = `TYPE_MUSIC_OUT;
                `TYPE_GP_IN: out_for = `TYPE_GP_OUT;
                default: out_for = `TYPE_NONE;
            endcase
        end
    endfunction

    wire [3:0] sel_idx = sel_slot - 4'h1;
    wire [2:0] cur_type = slot_type[sel_idx];
    wire [2:0] net_type = net_slot_type[3*sel_idx +: 3];
    wire other_busy = net_slot_busy[sel_idx];
    wire own_input = is_input(cur_type);
    wire view_only = locked | managed_mode; // [RULE7] [RULE11] [RULE14]

    // a candidate must keep the slot's established type
    reg cand_ok;
    always @* begin
        if (own_input)
            cand_ok = (cand_type == `TYPE_NONE) || (cand_type == cur_type); // [RULE19] [RULE21]
        else if (other_busy)
            cand_ok = (cand_type == `TYPE_NONE) || (cand_type == out_for(net_type)); // [RULE19]
        else
            cand_ok = !is_input(cand_type) ? (cand_type == `TYPE_NONE) : 1'b1;
    end

    // in-use shows inputs only, ours or a peer's
    assign slot_in_use = other_busy | own_input; // [RULE17]
    assign data_slot_display = sel_slot;
    assign lock_indicator = locked;
    assign confirm_pending_indicator = (state != ST_IDLE) & blink; // [RULE24]
    assign managed_indicator = (state == ST_MANAGED) ? blink : managed_mode; // [RULE5]

    // pair indicators, each channel from its pair
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_pair
            assign stereo_pair_indicator[g] = link_pairs[g/2]; // [RULE2]
        end
    endgenerate

    // flash timebase; free running keeps all flashing leds in phase
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            blink_cnt <= 32'h0;
            blink <= 1'b0;
        end else if (blink_cnt == BLINK_CYCLES - 1) begin
            blink_cnt <= 32'h0;
            blink <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // network stereo links: odd-even neighbours only, others dropped
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            link_pairs <= {PAIRS{1'b0}};
        end else if (link_evt && !link_first[0] && (link_second == link_first + 4'h1)) begin // [RULE1]
            link_pairs[link_first[3:1]] <= link_on; // [RULE2]
        end
    end

    // front-panel command interpreter
    integer i;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            locked <= 1'b0;
            managed_mode <= 1'b0;
            net_mode_manual <= 1'b0;
            saved_manual <= 1'b0;
            sel_slot <= `SLOT_FIRST;
            cand_type <= `TYPE_NONE;
            chan_active <= {CHANNELS{1'b0}};
            net_slot_display <= `CFG_RANGE_RST;
            assign_evt <= 1'b0;
            assign_slot <= `SLOT_FIRST;
            assign_type <= `TYPE_NONE;
            for (i = 0; i < SLOTS; i = i + 1)
                slot_type[i] <= `TYPE_NONE; // [RULE15]
        end else begin
            assign_evt <= 1'b0;
            // slot stepping is allowed except while a type change is pending; a query when locked
            if (p_inc && state != ST_TYPE) begin
                sel_slot <= (sel_slot == `SLOT_LAST) ? `SLOT_FIRST : sel_slot + 4'h1; // [RULE16]
            end else if (p_dec && state != ST_TYPE) begin
                sel_slot <= (sel_slot == `SLOT_FIRST) ? `SLOT_LAST : sel_slot - 4'h1; // [RULE16]
            end
            // channel buttons: query when view-only, else toggle that side
            for (i = 0; i < CHANNELS; i = i + 1) begin
                if (p_chan[i]) begin
                    if (view_only)
                        net_slot_display <= range_start + i[6:0]; // [RULE12] [RULE13] [RULE14]
                    else
                        chan_active[i] <= ~chan_active[i]; // [RULE3]
                end
            end
            case (state)
                ST_IDLE: begin
                    if (p_managed && is_control_master && !locked) begin
                        state <= ST_MANAGED; // [RULE4] [RULE5]
                    end else if (p_lock && !managed_mode) begin
                        state <= ST_LOCK; // [RULE9] [RULE10]
                    end else if (p_mode && is_control_master && !view_only) begin
                        state <= ST_MODE; // [RULE23]
                    end else if (p_type && !view_only) begin
                        cand_type <= (cur_type == `TYPE_LAST) ? `TYPE_NONE : cur_type + 3'h1; // [RULE20]
                        state <= ST_TYPE;
                    end
                end
                ST_MANAGED: begin
                    if (p_confirm) begin
                        state <= ST_IDLE;
                        managed_mode <= ~managed_mode; // [RULE5]
                        if (managed_mode)
                            net_mode_manual <= saved_manual; // [RULE6]
                        else
                            saved_manual <= net_mode_manual; // [RULE6]
                    end else if (p_cancel) begin
                        state <= ST_IDLE; // [RULE5] [RULE24]
                    end
                end
                ST_LOCK: begin
                    if (p_confirm) begin
                        state <= ST_IDLE;
                        locked <= ~locked; // [RULE8] [RULE9] [RULE10]
                        net_slot_display <= range_start;
                    end else if (p_cancel) begin
                        state <= ST_IDLE; // [RULE9] [RULE10]
                    end
                end
                ST_MODE: begin
                    if (p_confirm) begin
                        state <= ST_IDLE;
                        net_mode_manual <= ~net_mode_manual; // [RULE23]
                    end else if (p_cancel) begin
                        state <= ST_IDLE;
                    end
                end
                ST_TYPE: begin
                    if (p_type) begin
                        cand_type <= (cand_type == `TYPE_LAST) ? `TYPE_NONE : cand_type + 3'h1; // [RULE18] [RULE20]
                    end else if (p_confirm) begin
                        // an illegal candidate is dropped as if cancelled
                        state <= ST_IDLE;
                        if (cand_ok) begin
                            slot_type[sel_idx] <= cand_type; // [RULE20] [RULE21]
                            assign_evt <= 1'b1;
                            assign_slot <= sel_slot;
                            assign_type <= cand_type;
                        end
                    end else if (p_cancel) begin
                        state <= ST_IDLE; // [RULE20]
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // type leds: candidate while pending, else stored type, or the peer's type when a peer claims a slot that holds no input of ours
    always @* begin
        type_indicator = 6'h00;
        if (state == ST_TYPE)
            type_indicator[cand_type] = 1'b1; // [RULE20]
        else if (own_input || !other_busy)
            type_indicator[cur_type] = 1'b1;
        else
            type_indicator[net_type] = 1'b1;
    end

    // ahb-lite slave: zero wait states, okay always
    reg wr_pend;
    reg [7:0] wr_addr;
    wire take = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // write lands in the data phase
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            range_start <= `CFG_RANGE_RST;
        end else begin
            if (hready) begin
                wr_pend <= take & hwrite;
                wr_addr <= haddr;
            end
            if (wr_pend && wr_addr == `REG_CONFIG)
                range_start <= hwdata[`CFG_RANGE_MSB:`CFG_RANGE_LSB];
        end
    end

    // loaded at the address phase so it stands in the data phase
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h0;
        case (haddr)
            `REG_CONFIG: next_rdata[`CFG_RANGE_MSB:`CFG_RANGE_LSB] = range_start;
            `REG_STATUS: begin
                next_rdata[`ST_LOCKED] = locked;
                next_rdata[`ST_MANAGED] = managed_mode;
                next_rdata[`ST_MANUAL] = net_mode_manual;
                next_rdata[`ST_PENDING] = (state != ST_IDLE);
                next_rdata[`ST_SLOT_MSB:`ST_SLOT_LSB] = sel_slot;
                next_rdata[`ST_TYPE_MSB:`ST_TYPE_LSB] = cur_type;
            end
            `REG_CHAN: next_rdata[CHANNELS-1:0] = chan_active;
            `REG_LINK: next_rdata[PAIRS-1:0] = link_pairs;
            default: next_rdata = 32'h0;
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            hrdata <= 32'h0;
        else if (take && !hwrite)
            hrdata <= next_rdata;
    end
endmodule // front_panel_lock_and_cable_slots

`default_nettype wire

// >>> testbench/fp_checker_assertions.sv
// concurrent checks on the front panel block ports
`timescale 1ns/1ps
`default_nettype none
module fp_checker #(
    parameter CHANNELS = 16,
    parameter SLOTS = 14
) (
    input wire ref_clk, // clock
    input wire rst, // async reset
    input wire hreadyout, // slave ready
    input wire hresp, // response
    input wire link_evt, // link change pulse
    input wire [3:0] link_first, // first index
    input wire [3:0] link_second, // second index
    input wire link_on, // link or unlink
    input wire [CHANNELS-1:0] stereo_pair_indicator, // link leds
    input wire [3:0] data_slot_display, // selected slot
    input wire [SLOTS-1:0] net_slot_busy, // remote input claims
    input wire slot_in_use, // in-use led
    input wire is_control_master, // master flag
    input wire managed_mode, // managed state
    input wire net_mode_manual, // net mode
    input wire [CHANNELS-1:0] chan_active, // channel leds
    input wire lock_indicator, // edit lock
    input wire assign_evt, // assignment pulse
    input wire [3:0] assign_slot, // assigned slot
    input wire [2:0] assign_type // assigned type
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // the slave never stalls or errs
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
    a_pair_equal: assert property ((stereo_pair_indicator & 16'h5555) == ((stereo_pair_indicator >> 1) & 16'h5555))
        else $error("pair leds differ");
    a_link_reject: assert property (link_evt && link_on && link_first[0] |=> $stable(stereo_pair_indicator))
        else $error("even-odd link accepted");
    a_link_accept: assert property (link_evt && link_on && !link_first[0] && link_second == link_first + 4'h1
        |=> stereo_pair_indicator[$past(link_first)] && stereo_pair_indicator[$past(link_second)])
        else $error("valid link not shown");
    a_slot_range: assert property (data_slot_display >= 4'h1 && data_slot_display <= 4'he)
        else $error("slot out of range");
    a_in_use_net: assert property (net_slot_busy[data_slot_display - 4'h1] |-> slot_in_use)
        else $error("remote input not shown");
    a_managed_master: assert property ($rose(managed_mode) |-> $past(is_control_master))
        else $error("managed entered off master");
    a_mode_master: assert property ($changed(net_mode_manual) |-> $past(is_control_master))
        else $error("mode changed off master");
    a_managed_view: assert property (managed_mode && $past(managed_mode) |-> $stable(chan_active))
        else $error("edit while managed");
    a_locked_view: assert property (lock_indicator && $past(lock_indicator) |-> $stable(chan_active))
        else $error("edit while locked");
    a_assign_pulse: assert property (assign_evt |-> assign_type <= 3'h5 && assign_slot == data_slot_display ##1 !assign_evt)
        else $error("bad assignment event");
    c_lock: cover property ($rose(lock_indicator));
    c_managed: cover property ($rose(managed_mode));
    c_assign: cover property (assign_evt);
    c_link: cover property (link_evt && link_on && !link_first[0]);
endmodule // fp_checker
bind front_panel_lock_and_cable_slots fp_checker #(.CHANNELS(CHANNELS), .SLOTS(SLOTS)) fp_checker_i (
    .ref_clk(ref_clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp), .link_evt(link_evt),
    .link_first(link_first), .link_second(link_second), .link_on(link_on),
    .stereo_pair_indicator(stereo_pair_indicator), .data_slot_display(data_slot_display),
    .net_slot_busy(net_slot_busy), .slot_in_use(slot_in_use), .is_control_master(is_control_master),
    .managed_mode(managed_mode), .net_mode_manual(net_mode_manual), .chan_active(chan_active),
    .lock_indicator(lock_indicator), .assign_evt(assign_evt), .assign_slot(assign_slot), .assign_type(assign_type));
`default_nettype wire

// >>> testbench/net_peer.sv
// model of the peer modules and network master
`timescale 1ns/1ps
`default_nettype none
module net_peer (
    input wire logic ref_clk, // system clock
    output var logic is_control_master, // master flag
    output var logic link_evt, // link change pulse
    output var logic [3:0] link_first, // first channel index
    output var logic [3:0] link_second, // second channel index
    output var logic link_on, // link or unlink
    output var logic [13:0] net_slot_busy, // input claims of peers
    output var logic [41:0] net_slot_type // peer types per slot
);
    // idle network: not master, no link, no claim
    initial begin
        is_control_master = 1'b0;
        link_evt = 1'b0;
        link_first = 4'h0;
        link_second = 4'h0;
        link_on = 1'b0;
        net_slot_busy = 14'h0;
        net_slot_type = 42'h0;
    end
    task set_master(input logic m);
        @(posedge ref_clk);
        is_control_master <= m;
    endtask
    // an input module links a pair; indices are inverted after the pulse
    task link_pair(input logic [3:0] f, input logic [3:0] s);
        @(posedge ref_clk);
        link_evt <= 1'b1;
        link_first <= f;
        link_second <= s;
        link_on <= 1'b1;
        @(posedge ref_clk);
        link_evt <= 1'b0;
        link_first <= ~f;
        link_second <= ~s;
    endtask
    // a peer assignment; only inputs claim the slot
    task claim(input int k, input logic [2:0] t, input logic b);
        @(posedge ref_clk);
        net_slot_busy[k-1] <= b;
        net_slot_type[3*(k-1)+:3] <= t;
    endtask
endmodule // net_peer
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the front panel block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, rdv;
    logic [7:0] btn = 8'h00; // managed lock confirm cancel mode inc dec type
    logic [15:0] chan = 16'h0000;
    wire hreadyout, hresp, link_evt, link_on, is_master, slot_in_use, cpi, mind, lock_ind, managed, manual, aevt;
    wire [31:0] hrdata;
    wire [3:0] lf, ls, dsd, aslot;
    wire [13:0] busy;
    wire [41:0] ntype;
    wire [15:0] chan_active, pair_led;
    wire [6:0] nsd;
    wire [5:0] tind;
    wire [2:0] atype;
    int fail_count = 0, total_checks = 0;
    always #10 ref_clk = ~ref_clk;
    net_peer net_peer_i (.ref_clk(ref_clk), .is_control_master(is_master), .link_evt(link_evt), .link_first(lf),
        .link_second(ls), .link_on(link_on), .net_slot_busy(busy), .net_slot_type(ntype));
    front_panel_lock_and_cable_slots #(.BLINK_CYCLES(4)) front_panel_lock_and_cable_slots_i (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .btn_managed(btn[0]), .btn_lock(btn[1]), .btn_confirm(btn[2]), .btn_cancel(btn[3]), .btn_mode(btn[4]),
        .btn_slot_inc(btn[5]), .btn_slot_dec(btn[6]), .btn_type_sel(btn[7]), .btn_chan(chan),
        .is_control_master(is_master), .link_evt(link_evt), .link_first(lf), .link_second(ls), .link_on(link_on),
        .net_slot_busy(busy), .net_slot_type(ntype), .chan_active(chan_active), .stereo_pair_indicator(pair_led),
        .net_slot_display(nsd), .data_slot_display(dsd), .slot_in_use(slot_in_use), .type_indicator(tind),
        .confirm_pending_indicator(cpi), .managed_indicator(mind), .lock_indicator(lock_ind),
        .managed_mode(managed), .net_mode_manual(manual), .assign_evt(aevt), .assign_slot(aslot), .assign_type(atype));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // single word transfer; read data taken at the second ready edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        hsel <= 1'b0;
    endtask
    // held past the sync pipeline, then a quiet gap
    task press(input int i);
        @(posedge ref_clk);
        if (i < 8) btn[i] <= 1'b1; else chan[i-8] <= 1'b1;
        repeat (6) @(posedge ref_clk);
        btn <= 8'h00; chan <= 16'h0000;
        repeat (6) @(posedge ref_clk);
    endtask
    task status(input logic [31:0] e, input string n);
        bus(1'b0, 8'h04, 32'h0);
        chk(n, rdv, e);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog, far above the test length
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        bus(1'b0, 8'h00, 32'h0); chk("config", rdv, 32'h1);
        status(32'h100, "status reset");
        bus(1'b0, 8'h10, 32'h0); chk("unmapped", rdv, 32'h0);
        bus(1'b1, 8'h04, 32'hf); status(32'h100, "status ro");
        bus(1'b1, 8'h00, 32'h11); bus(1'b0, 8'h00, 32'h0); chk("config wr", rdv, 32'h11);
        press(6); chk("dec wrap", dsd, 4'he);
        press(5); chk("inc wrap", dsd, 4'h1);
        press(8); chk("chan toggle", chan_active, 16'h1);
        net_peer_i.link_pair(4'h0, 4'h1);
        net_peer_i.link_pair(4'h1, 4'h2);
        @(posedge ref_clk); chk("pair led", pair_led, 16'h3);
        bus(1'b0, 8'h0c, 32'h0); chk("link reg", rdv, 32'h1);
        press(1); status(32'h108, "lock pending");
        press(3); status(32'h100, "lock cancel"); chk("cpi off", cpi, 1'b0);
        press(1); press(2); chk("locked", lock_ind, 1'b1);
        press(9); chk("query", nsd, 7'h12);
        chk("query keeps", chan_active, 16'h1);
        press(4); press(7); status(32'h101, "locked ignores");
        press(1); press(3); chk("unlock cancel", lock_ind, 1'b1);
        press(1); press(2); chk("unlock", lock_ind, 1'b0);
        press(0); status(32'h100, "not master");
        press(4); status(32'h100, "mode not master");
        net_peer_i.set_master(1'b1);
        press(4); press(2); chk("manual", manual, 1'b1);
        press(0); status(32'h10c, "managed pending");
        press(3); chk("managed cancel", managed, 1'b0);
        press(0); press(2); chk("managed on", managed, 1'b1); chk("mind on", mind, 1'b1);
        press(10); chk("managed query", nsd, 7'h13);
        chk("managed keeps", chan_active, 16'h1);
        press(1); status(32'h106, "lock in managed");
        press(0); press(2); chk("managed off", managed, 1'b0); chk("mind off", mind, 1'b0);
        chk("mode restored", manual, 1'b1);
        net_peer_i.claim(2, 3'h1, 1'b1);
        net_peer_i.claim(3, 3'h3, 1'b0);
        press(5); chk("remote in use", slot_in_use, 1'b1);
        press(7); press(7); press(2); status(32'h204, "illegal type");
        chk("no event", atype, 3'h0);
        press(5); chk("output only", slot_in_use, 1'b0);
        press(6); press(6); press(7); chk("candidate", tind, 6'h02);
        press(2); chk("assign type", atype, 3'h1);
        chk("assign slot", aslot, 4'h1);
        chk("local in use", slot_in_use, 1'b1);
        for (int k = 0; k < 5; k++) press(7);
        press(2); chk("release", atype, 3'h0);
        chk("released use", slot_in_use, 1'b0);
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
